/* acts_adc_ctl.sv */
// Converter control: input select decode, conversion clock and trigger select
`timescale 1ns/1ps

module acts_adc_ctl (
	input  wire logic        CLK_I,         // Bus clock, 25 MHz
	input  wire logic        RST_N_I,       // Synchronous reset, active low
	input  wire logic        PSEL,          // APB select
	input  wire logic        PENABLE,       // APB enable
	input  wire logic        PWRITE,        // APB direction
	input  wire logic [7:0]  PADDR,         // APB byte address
	input  wire logic [31:0] PWDATA,        // APB write data
	output logic      [31:0] PRDATA,        // APB read data
	output logic             PREADY,        // APB ready
	output logic             PSLVERR,       // APB error, unmapped address
	input  wire logic        WAIT_I,        // Processor in wait mode
	input  wire logic        DEEPEST_RETAINED_STOP_MODE_I,       // Deepest retained stop mode
	input  wire logic        LOC_TICK_I,    // Local async conversion clock tick
	input  wire logic        OSC_OUT_I,     // Oscillator output tick
	input  wire logic        MODULO_TIMER_ZERO_OVF_I,   // Modulo timer zero overflow
	input  wire logic        RTC_OVF_I,     // Real-time counter overflow
	input  wire logic        SIX_MATCH_I,   // Six-channel timer match trigger
	input  wire logic        SIX_INIT_I,    // Six-channel timer init trigger
	input  wire logic        CORE_DONE_I,   // Converter core finished
	input  wire logic [11:0] CORE_RESULT_I, // Converter core result
	output logic      [4:0]  CH_SEL_O,      // Input select code to mux
	output logic      [2:0]  ROUTE_O,       // Decoded source kind
	output logic             CONV_EN_O,     // Converter enabled
	output logic             LONG_SMP_O,    // Long sample request
	output logic             CONV_CLK_O,    // Conversion clock tick
	output logic             START_O        // Start conversion pulse
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0]          sel;
		logic [1:0]          csrc;
		logic [1:0]          div;
		logic [1:0]          tsrc;
		logic                hw_en;
		logic                long_smp;
		logic [7:0]          dly;
		logic                en;
		acts_pkg::acts_route_e route;
		logic                done;
		logic [11:0]         result;
		logic                half;
		logic [2:0]          div_cnt;
		logic [7:0]          dly_cnt;
		acts_pkg::acts_state_e state;
		logic                pready;
		logic                pslverr;
		logic [31:0]         prdata;
		logic                start;
		logic                ctick;
	} acts_s;

	acts_s r;
	acts_s next_r;
	logic  wr_go;
	logic  src_tick;
	logic  trg;
	logic  trg_ok;
	logic  hw_go;
	logic  mapped;
	logic [2:0] mask;
	logic [4:0] wsel;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		mapped = (PADDR == acts_pkg::OFS_CTRL) || (PADDR == acts_pkg::OFS_STATUS) ||
			(PADDR == acts_pkg::OFS_RESULT);
		wr_go  = PSEL && PENABLE && r.pready && PWRITE;
		wsel   = PWDATA[acts_pkg::POS_SEL +: 5];
		// Bus slave, one wait state, read data latched in the first access cycle
		next_r.pready  = PSEL && PENABLE && !r.pready;
		next_r.pslverr = PSEL && PENABLE && !r.pready && !mapped;
		next_r.prdata  = 32'h0;
		if (PSEL && PENABLE && !r.pready && !PWRITE) begin
			case (PADDR)
				acts_pkg::OFS_CTRL: begin
					next_r.prdata = {8'h00, r.dly, 3'h0, r.long_smp, r.hw_en, r.tsrc, r.div, r.csrc, r.sel};
				end
				acts_pkg::OFS_STATUS: begin
					next_r.prdata = {29'h0, r.route == acts_pkg::ROUTE_RSV, r.done, r.state != acts_pkg::ST_IDLE};
				end
				acts_pkg::OFS_RESULT: next_r.prdata = {20'h0, r.result};
				default: next_r.prdata = 32'h0;
			endcase
		end
		if (wr_go && PADDR == acts_pkg::OFS_CTRL) begin
			next_r.sel      = wsel;
			next_r.csrc     = PWDATA[acts_pkg::POS_CSRC +: 2];
			next_r.div      = PWDATA[acts_pkg::POS_DIV +: 2];
			next_r.tsrc     = PWDATA[acts_pkg::POS_TSRC +: 2];
			next_r.hw_en    = PWDATA[acts_pkg::POS_HWEN];
			next_r.long_smp = PWDATA[acts_pkg::POS_LONG];
			next_r.dly      = PWDATA[acts_pkg::POS_DLY +: 8];
		end
		// Done flag cleared by writing one; completion below wins
		if (wr_go && PADDR == acts_pkg::OFS_STATUS && PWDATA[acts_pkg::POS_DONE])
			next_r.done = 1'b0;
		// Input select decode to mux routing
		next_r.en = (next_r.sel != acts_pkg::SEL_OFF);
		if (next_r.sel[4] == 1'b0)
			next_r.route = acts_pkg::ROUTE_EXT;
		else if (next_r.sel <= acts_pkg::SEL_GND_HI)
			next_r.route = acts_pkg::ROUTE_GND;
		else if (next_r.sel == acts_pkg::SEL_TEMP)
			next_r.route = acts_pkg::ROUTE_TEMP;
		else if (next_r.sel == acts_pkg::SEL_BGAP)
			next_r.route = acts_pkg::ROUTE_BGAP;
		else if (next_r.sel == acts_pkg::SEL_REFH)
			next_r.route = acts_pkg::ROUTE_REFH;
		else if (next_r.sel == acts_pkg::SEL_REFL)
			next_r.route = acts_pkg::ROUTE_REFL;
		else if (next_r.sel == acts_pkg::SEL_OFF)
			next_r.route = acts_pkg::ROUTE_OFF;
		else
			next_r.route = acts_pkg::ROUTE_RSV;
		// Conversion clock source select; alternate gated only in stop, not wait
		next_r.half = !r.half;
		case (r.csrc)
			acts_pkg::CSRC_BUS:  src_tick = 1'b1;
			acts_pkg::CSRC_BUS2: src_tick = r.half;
			acts_pkg::CSRC_LOC:  src_tick = LOC_TICK_I;
			default:             src_tick = OSC_OUT_I && !DEEPEST_RETAINED_STOP_MODE_I;
		endcase
		// Divider by 1, 2, 4 or 8
		mask = {r.div == 2'h3, r.div[1], r.div != 2'h0};
		next_r.ctick = 1'b0;
		if (src_tick) begin
			next_r.div_cnt = (r.div_cnt >= mask) ? 3'h0 : r.div_cnt + 3'h1;
			next_r.ctick   = (r.div_cnt >= mask);
		end
		// Hardware trigger select and mode gating
		case (r.tsrc)
			acts_pkg::TSRC_MTIM: trg = MODULO_TIMER_ZERO_OVF_I;
			acts_pkg::TSRC_RTC:  trg = RTC_OVF_I;
			acts_pkg::TSRC_MTCH: trg = SIX_MATCH_I;
			default:             trg = SIX_INIT_I;
		endcase
		trg_ok = !DEEPEST_RETAINED_STOP_MODE_I || (r.tsrc == acts_pkg::TSRC_RTC);
		hw_go  = r.hw_en && r.en && trg && trg_ok;
		// Conversion sequencer
		next_r.start = 1'b0;
		case (r.state)
			acts_pkg::ST_IDLE: begin
				if (hw_go && r.tsrc[1]) begin
					next_r.state   = acts_pkg::ST_DLY;
					next_r.dly_cnt = r.dly;
				end else if (hw_go) begin
					next_r.state = acts_pkg::ST_CONV;
					next_r.start = 1'b1;
				end else if (wr_go && PADDR == acts_pkg::OFS_CTRL &&
					!PWDATA[acts_pkg::POS_HWEN] && wsel != acts_pkg::SEL_OFF) begin
					next_r.state = acts_pkg::ST_CONV;
					next_r.start = 1'b1;
				end
			end
			acts_pkg::ST_DLY: begin
				if (r.dly_cnt == 8'h00) begin
					next_r.state = acts_pkg::ST_CONV;
					next_r.start = 1'b1;
				end else begin
					next_r.dly_cnt = r.dly_cnt - 8'h01;
				end
			end
			acts_pkg::ST_CONV: begin
				if (CORE_DONE_I) begin
					next_r.state  = acts_pkg::ST_IDLE;
					next_r.result = CORE_RESULT_I;
					next_r.done   = 1'b1;
				end
			end
			default: next_r.state = acts_pkg::ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Register
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			r          <= '0;
			r.sel      <= acts_pkg::RST_SEL;
			r.csrc     <= acts_pkg::RST_CSRC;
			r.div      <= acts_pkg::RST_DIV;
			r.tsrc     <= acts_pkg::RST_TSRC;
			r.dly      <= acts_pkg::RST_DLY;
			r.route    <= acts_pkg::ROUTE_OFF;
			r.state    <= acts_pkg::ST_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from flops
	assign PRDATA     = r.prdata;
	assign PREADY     = r.pready;
	assign PSLVERR    = r.pslverr;
	assign CH_SEL_O   = r.sel;
	assign ROUTE_O    = r.route;
	assign CONV_EN_O  = r.en;
	assign LONG_SMP_O = r.long_smp;
	assign CONV_CLK_O = r.ctick;
	assign START_O    = r.start;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	AST_OFF_DECODE: assert property (
		(wr_go && PADDR == acts_pkg::OFS_CTRL && wsel == acts_pkg::SEL_OFF) |=> (!CONV_EN_O && ROUTE_O == 3'h7))
		else $error("off code did not disable converter");
	AST_RSV_FLAG: assert property (
		(wr_go && PADDR == acts_pkg::OFS_CTRL && wsel == 5'h13) |=> ROUTE_O == 3'h6)
		else $error("reserved code not flagged");
	// Reset sampled in the antecedent: the tick flop is still cleared at the release edge
	AST_BUS_CLK: assert property (
		(RST_N_I && r.csrc == acts_pkg::CSRC_BUS && r.div == 2'h0) |=> CONV_CLK_O)
		else $error("undivided bus clock missed a tick");
	AST_ALT_OSC: assert property (
		(r.csrc == acts_pkg::CSRC_ALT && r.div == 2'h0 && OSC_OUT_I && !DEEPEST_RETAINED_STOP_MODE_I) |=> CONV_CLK_O)
		else $error("oscillator tick not passed on");
	// Divide by eight ticks only from the last count; survives a reconfiguration mid-gap
	AST_DIV_GAP: assert property (
		(r.div == 2'h3 && r.div_cnt != 3'h7) |=> !CONV_CLK_O)
		else $error("divide by eight ticked early");
	AST_ALT_WAIT: assert property (
		(WAIT_I && r.csrc == acts_pkg::CSRC_ALT && r.div == 2'h0 && OSC_OUT_I && !DEEPEST_RETAINED_STOP_MODE_I) |=> CONV_CLK_O)
		else $error("alternate clock stalled in wait");
	AST_DLY_FIRE: assert property (
		(r.state == acts_pkg::ST_DLY && r.dly_cnt == 8'h00) |=> (START_O && r.state == acts_pkg::ST_CONV))
		else $error("delayed trigger did not start");
	AST_WAIT_TRIG: assert property (
		(WAIT_I && !DEEPEST_RETAINED_STOP_MODE_I && r.state == acts_pkg::ST_IDLE && r.hw_en && r.en &&
			r.tsrc == acts_pkg::TSRC_MTIM && MODULO_TIMER_ZERO_OVF_I) |=> START_O)
		else $error("timer trigger lost in wait");
	AST_STOP_BLOCK: assert property (
		(DEEPEST_RETAINED_STOP_MODE_I && r.state == acts_pkg::ST_IDLE && r.tsrc != acts_pkg::TSRC_RTC && !wr_go) |=> !START_O)
		else $error("non-counter trigger started in stop");
	AST_SW_IGNORE: assert property (
		(!r.hw_en && r.state == acts_pkg::ST_IDLE && !wr_go) |=> (!START_O && r.state == acts_pkg::ST_IDLE))
		else $error("trigger pulse started software mode");

	COV_DELAYED: cover property (r.state == acts_pkg::ST_DLY ##[1:20] START_O);
	COV_STOP_RTC: cover property (DEEPEST_RETAINED_STOP_MODE_I && r.tsrc == acts_pkg::TSRC_RTC ##1 START_O);
	COV_DONE: cover property (r.state == acts_pkg::ST_CONV ##1 r.done);
endmodule : acts_adc_ctl

/* acts_core_model.sv */
// Converter core model: answers each start pulse taken while idle after a set latency
`timescale 1ns/1ps
module acts_core_model (
	input  wire logic        clk_i,    // Bus clock
	input  wire logic        rst_n_i,  // Reset, active low
	input  wire logic        start_i,  // Start conversion pulse
	input  wire logic [7:0]  lat_i,    // Cycles until finished, less one
	input  wire logic [11:0] res_i,    // Value to hand back
	output logic             done_o,   // Finished pulse
	output logic      [11:0] result_o  // Result, valid with done only
);
	logic       busy;
	logic [7:0] cnt;
	// Count the conversion down; result lines wobble outside the done cycle
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		result_o <= ~result_o;
		if (!rst_n_i) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			result_o <= 12'h000;
		end else if (busy) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h00) begin
				busy <= 1'b0;
				done_o <= 1'b1;
				result_o <= res_i;
			end
		end else if (start_i) begin
			busy <= 1'b1;
			cnt <= lat_i;
		end
	end
endmodule : acts_core_model

/* acts_pkg.sv */
// Package: register map, field layout and encodings of the converter control block
package acts_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int POS_SEL  = 0;  // input_select_code, 5 bits
	localparam int POS_CSRC = 5;  // clock source, 2 bits
	localparam int POS_DIV  = 7;  // clock_divide_select, 2 bits
	localparam int POS_TSRC = 9;  // trigger source, 2 bits
	localparam int POS_HWEN = 11; // hardware trigger enable
	localparam int POS_LONG = 12; // long sample
	localparam int POS_DLY  = 16; // trigger delay, 8 bits
	// Status field positions
	localparam int POS_BUSY = 0;
	localparam int POS_DONE = 1;
	localparam int POS_RSV  = 2;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [4:0] RST_SEL  = 5'h1f; // converter off
	localparam logic [1:0] RST_CSRC = 2'h0;
	localparam logic [1:0] RST_DIV  = 2'h0;
	localparam logic [1:0] RST_TSRC = 2'h0;
	localparam logic [7:0] RST_DLY  = 8'h00;
	// ----------------------------------------------------------------
	// Input select codes
	// ----------------------------------------------------------------
	localparam logic [4:0] SEL_GND_LO = 5'h10;
	localparam logic [4:0] SEL_GND_HI = 5'h12;
	localparam logic [4:0] SEL_TEMP   = 5'h16;
	localparam logic [4:0] SEL_BGAP   = 5'h17;
	localparam logic [4:0] SEL_REFH   = 5'h1d;
	localparam logic [4:0] SEL_REFL   = 5'h1e;
	localparam logic [4:0] SEL_OFF    = 5'h1f;
	// Routing of the analog multiplexer
	typedef enum logic [2:0] {
		ROUTE_EXT  = 3'h0,
		ROUTE_GND  = 3'h1,
		ROUTE_TEMP = 3'h2,
		ROUTE_BGAP = 3'h3,
		ROUTE_REFH = 3'h4,
		ROUTE_REFL = 3'h5,
		ROUTE_RSV  = 3'h6,
		ROUTE_OFF  = 3'h7
	} acts_route_e;
	// Clock sources and trigger sources
	localparam logic [1:0] CSRC_BUS  = 2'h0;
	localparam logic [1:0] CSRC_BUS2 = 2'h1;
	localparam logic [1:0] CSRC_LOC  = 2'h2;
	localparam logic [1:0] CSRC_ALT  = 2'h3;
	localparam logic [1:0] TSRC_MTIM = 2'h0;
	localparam logic [1:0] TSRC_RTC  = 2'h1;
	localparam logic [1:0] TSRC_MTCH = 2'h2;
	localparam logic [1:0] TSRC_INIT = 2'h3;
	// Conversion sequencer states, Gray along idle, delay, convert
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_DLY  = 2'h1,
		ST_CONV = 2'h3
	} acts_state_e;
endpackage : acts_pkg

/* testbench.sv */
// Testbench: register access, input decode, conversion clock and trigger checks
`timescale 1ns/1ps
module testbench;
	logic        CLK_I = 1'b0, RST_N_I = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd, seed = 32'h2;
	logic        PREADY, PSLVERR, CONV_EN_O, LONG_SMP_O, CONV_CLK_O, START_O, CORE_DONE_I, er;
	logic        WAIT_I = 1'b0, DEEPEST_RETAINED_STOP_MODE_I = 1'b0, LOC_TICK_I = 1'b0, OSC_OUT_I = 1'b0;
	logic [3:0]  trig = 4'h0;
	logic [11:0] CORE_RESULT_I, core_res = 12'h0;
	logic [7:0]  core_lat = 8'h3;
	logic [4:0]  CH_SEL_O, code;
	logic [2:0]  ROUTE_O;
	int          n_mismatch = 0, n_checks = 0, cyc = 0, lat, p, m, s, c, d;
	acts_adc_ctl acts_adc_ctl_i (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .WAIT_I(WAIT_I), .DEEPEST_RETAINED_STOP_MODE_I(DEEPEST_RETAINED_STOP_MODE_I), .LOC_TICK_I(LOC_TICK_I),
		.OSC_OUT_I(OSC_OUT_I), .MODULO_TIMER_ZERO_OVF_I(trig[0]), .RTC_OVF_I(trig[1]), .SIX_MATCH_I(trig[2]),
		.SIX_INIT_I(trig[3]), .CORE_DONE_I(CORE_DONE_I), .CORE_RESULT_I(CORE_RESULT_I),
		.CH_SEL_O(CH_SEL_O), .ROUTE_O(ROUTE_O), .CONV_EN_O(CONV_EN_O), .LONG_SMP_O(LONG_SMP_O),
		.CONV_CLK_O(CONV_CLK_O), .START_O(START_O));
	acts_core_model acts_core_model_i (.clk_i(CLK_I), .rst_n_i(RST_N_I), .start_i(START_O),
		.lat_i(core_lat), .res_i(core_res), .done_o(CORE_DONE_I), .result_o(CORE_RESULT_I));
	// ------------------------------------------------------------
	// Clock, tick sources and hang guard
	// ------------------------------------------------------------
	always #20 CLK_I = ~CLK_I;
	always @(posedge CLK_I) begin
		cyc++;
		LOC_TICK_I <= (cyc % 3 == 0);
		OSC_OUT_I <= (cyc % 5 == 1);
		if (cyc > 40000) begin
			n_mismatch++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	// Control word from its fields
	function automatic logic [31:0] ctrl(input logic [4:0] cd, input logic [1:0] cs, input logic [1:0] dv,
		input logic [1:0] ts, input logic hw, input logic lg, input logic [7:0] dl);
		return {8'h00, dl, 3'h0, lg, hw, ts, dv, cs, cd};
	endfunction : ctrl
	// Expected source kind of an input select code
	function automatic logic [2:0] route_of(input logic [4:0] cd);
		if (cd < 5'h10) return 3'h0;
		if (cd <= 5'h12) return 3'h1;
		case (cd)
			5'h16: return 3'h2;
			5'h17: return 3'h3;
			5'h1d: return 3'h4;
			5'h1e: return 3'h5;
			5'h1f: return 3'h7;
			default: return 3'h6;
		endcase
	endfunction : route_of
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge CLK_I);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= dat;
		@(posedge CLK_I);
		PENABLE <= 1'b1;
		do @(posedge CLK_I); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	// Pulse one trigger input, return cycles until the start pulse (0 for none)
	task automatic fire(input int src, output int l);
		@(posedge CLK_I);
		trig <= 4'(1 << src);
		l = 0;
		for (int k = 1; k <= 260 && l == 0; k++) begin
			@(posedge CLK_I);
			trig <= 4'h0;
			#1;
			if (START_O === 1'b1) l = k;
		end
	endtask : fire
	// Wait for the conversion, then check flags and result
	task automatic done_chk();
		for (int k = 0; k < 40; k++) begin
			apb(1'b0, acts_pkg::OFS_STATUS, 32'h0);
			if (rd[acts_pkg::POS_BUSY] === 1'b0) break;
		end
		chk(rd & 32'h3, 32'h2);
		apb(1'b0, acts_pkg::OFS_RESULT, 32'h0);
		chk(rd, {20'h0, core_res});
		apb(1'b1, acts_pkg::OFS_STATUS, 32'h2);
	endtask : done_chk
	// Count conversion clock pulses over 64 cycles against the source ticks
	task automatic clk_run(input logic [1:0] cs, input logic [1:0] dv, output int pc);
		int t;
		apb(1'b1, acts_pkg::OFS_CTRL, ctrl(5'h00, cs, dv, 2'h0, 1'b1, 1'b0, 8'h00));
		pc = 0;
		t = 0;
		repeat (64) begin
			@(posedge CLK_I);
			pc += int'(CONV_CLK_O === 1'b1);
			t += int'(cs == 2'h2 ? LOC_TICK_I : cs == 2'h3 ? OSC_OUT_I & !DEEPEST_RETAINED_STOP_MODE_I : 1'b1);
		end
		if (cs == 2'h1) t = t / 2;
		chk(32'(pc - (t >> dv) <= 2 && (t >> dv) - pc <= 2), 32'h1);
	endtask : clk_run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		#1 chk(32'(ROUTE_O), 32'h7);
		apb(1'b0, acts_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h1f);
		apb(1'b1, 8'h0c, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		// Every input select code, with its reserved flag
		for (c = 0; c < 32; c++) begin
			apb(1'b1, acts_pkg::OFS_CTRL, ctrl(5'(c), 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 8'h00));
			#1 chk({CH_SEL_O, ROUTE_O, CONV_EN_O}, {5'(c), route_of(5'(c)), c != 31});
			apb(1'b0, acts_pkg::OFS_STATUS, 32'h0);
			chk(32'(rd[acts_pkg::POS_RSV]), 32'(route_of(5'(c)) == 3'h6));
		end
		// All clock sources and dividers; the alternate one in wait, then gated off in stop
		for (c = 0; c < 16; c++) begin
			WAIT_I <= (c >= 12);
			clk_run(2'(c >> 2), 2'(c), p);
		end
		DEEPEST_RETAINED_STOP_MODE_I <= 1'b1;
		clk_run(acts_pkg::CSRC_ALT, 2'h0, p);
		chk(32'(p), 32'h0);
		// Trigger sources in run, wait and stop; bus clock in stop
		for (m = 0; m < 3; m++) begin
			for (s = 0; s < 4; s++) begin
				@(posedge CLK_I);
				WAIT_I <= (m == 1);
				DEEPEST_RETAINED_STOP_MODE_I <= (m == 2);
				d = (m == 0 && s == 2) ? 255 : int'(rnd() & 32'hf);
				core_res <= 12'(rnd());
				core_lat <= 8'(rnd() & 32'hf);
				code = 5'(rnd() & 32'hf);
				apb(1'b1, acts_pkg::OFS_CTRL, ctrl(code, 2'h0, 2'h0, 2'(s), 1'b1, 1'b0, 8'(d)));
				fire((s + 1) % 4, lat);
				chk(32'(lat), 32'h0);
				fire(s, lat);
				chk(32'(lat), (m == 2 && s != 1) ? 32'h0 : (s < 2 ? 32'h1 : 32'(d + 2)));
				if (lat != 0) done_chk();
			end
		end
		@(posedge CLK_I);
		WAIT_I <= 1'b0;
		DEEPEST_RETAINED_STOP_MODE_I <= 1'b0;
		// Software start, then hardware pulse refused with hardware mode off
		apb(1'b1, acts_pkg::OFS_CTRL, ctrl(5'h03, 2'h0, 2'h0, 2'h1, 1'b0, 1'b0, 8'h00));
		#1 chk(32'(START_O), 32'h1);
		done_chk();
		fire(1, lat);
		chk(32'(lat), 32'h0);
		// Temperature reading: long sample, slow local clock, bandgap first
		for (c = 0; c < 2; c++) begin
			code = c == 0 ? acts_pkg::SEL_BGAP : acts_pkg::SEL_TEMP;
			apb(1'b1, acts_pkg::OFS_CTRL, ctrl(code, acts_pkg::CSRC_LOC, 2'h3, 2'h0, 1'b0, 1'b1, 8'h00));
			#1 chk({START_O, LONG_SMP_O, ROUTE_O}, {2'b11, route_of(code)});
			done_chk();
		end
		stop_test();
	end
endmodule : testbench
